// ===== core/colour_palette_lookup.sv
// Colour palette look-up: pixel sampling, masked table look-up, colour
// outputs, and the asynchronous host register port.
// Assumes every pin input is asynchronous to i_mclk and slow enough
// (pixel clock and host strobes) to be seen through a two-flop synchroniser.
//
// Behaviour
// - Take pixel index and blank at each rising edge of the pixel clock.
// - Samples pass a three-stage pipeline before reaching the colour outputs.
// - Index ANDed with pixel mask addresses the palette table.
// - Blank sampled low forces all colour outputs to zero.
// - Red, green and blue each take a 6-bit code from the entry.
// - Palette holds 256 entries of three 6-bit components.
// - Register select latched at the falling edge of the active strobe.
// - Write data stored into the selected register at write strobe rise.
// - Read drives selected register on the bus, released at read rise.
// - Host spaces accesses so the device finishes each one internally.
// - Host transfers use an 8-bit two-way bus, direction set by strobe.
// - Mask writes change displayed entries at once, table untouched.
// - Selects 0,0 write address, 1,1 read address, 0,1 colour value.
// - Colour transfers are red, green, blue bytes, low six bits used.
// - Write address restarts sequence; third byte stores entry, increments address.
// - Read address loads buffer, increments; third read byte reloads, increments.
module colour_palette_lookup (
  input  wire logic                         i_mclk,
  input  wire logic                         i_reset,
  input  wire logic                         i_pixel_clock,
  input  wire logic [palette_pkg::PIXEL_W-1:0]  i_pixel_index_in,
  input  wire logic                         i_blank_n,
  input  wire logic                         i_rd_n,
  input  wire logic                         i_wr_n,
  input  wire logic [palette_pkg::SEL_W-1:0]    i_register_select,
  input  wire logic [palette_pkg::DATA_W-1:0]   i_program_data_bus,
  output logic      [palette_pkg::DATA_W-1:0]   o_program_data_bus,
  output logic                              o_program_data_bus_oe,
  output logic      [palette_pkg::COLOUR_W-1:0] o_red,
  output logic      [palette_pkg::COLOUR_W-1:0] o_green,
  output logic      [palette_pkg::COLOUR_W-1:0] o_blue,
  output logic                              o_pixel_ready,
  output logic                              o_host_ack
);
  import palette_pkg::*;

  typedef struct packed {
    // Pin synchroniser and edge history
    logic [PIN_W-1:0]    meta;
    logic [PIN_W-1:0]    sync;
    logic                pclk_prev;
    logic                rd_prev_n;
    logic                wr_prev_n;

    // Host port registers
    logic [SEL_W-1:0]    sel;
    logic [PIXEL_W-1:0]  addr;
    logic [PIXEL_W-1:0]  mask;

    // Colour value buffer between host and table
    logic [ENTRY_W-1:0]  cbuf;
    phase_e              phase;

    // Bus drive and acknowledge
    logic [DATA_W-1:0]   rd_data;
    logic                oe;
    logic                ack;

    // Pixel pipeline
    logic                s1_valid;
    logic                s1_blank_n;
    logic [PIXEL_W-1:0]  s1_addr;
    logic                s2_valid;
    logic                s2_blank_n;
    logic [ENTRY_W-1:0]  s2_entry;
    logic [COLOUR_W-1:0] red;
    logic [COLOUR_W-1:0] green;
    logic [COLOUR_W-1:0] blue;
  } state_s;

  state_s              q;
  state_s              d;
  logic [ENTRY_W-1:0]  palette [ENTRIES];

  // Synchronised pins and their edges
  logic [PIN_W-1:0]    pins;
  logic                pclk_s;
  logic                rd_n_s;
  logic                wr_n_s;
  logic [SEL_W-1:0]    sel_s;
  logic [DATA_W-1:0]   data_s;
  logic                pclk_rise;
  logic                rd_fall;
  logic                rd_rise;
  logic                wr_fall;
  logic                wr_rise;

  // Table transfer arbitration and write port
  logic                tbl_busy;
  logic                pal_we;
  logic [PIXEL_W-1:0]  pal_wa;
  logic [ENTRY_W-1:0]  pal_wd;

  // Pixel FIFO
  logic                fifo_out_valid;
  logic                fifo_pop;
  logic [SAMPLE_W-1:0] fifo_out_data;
  logic [SAMPLE_W-1:0] sample_in;

  // One word so that every pin passes the same two flops; strobe and data
  // therefore arrive aligned, which the write capture relies on
  assign pins = {
    i_pixel_clock,        // 21
    i_blank_n,            // 20
    i_pixel_index_in,     // 19:12
    i_rd_n,               // 11
    i_wr_n,               // 10
    i_register_select,    // 9:8
    i_program_data_bus    // 7:0
  };

  // Edges are taken only from the second synchroniser stage
  assign pclk_s = q.sync[PIN_PCLK];
  assign rd_n_s = q.sync[PIN_RD_N];
  assign wr_n_s = q.sync[PIN_WR_N];
  assign sel_s  = q.sync[PIN_SEL_LSB +: SEL_W];
  assign data_s = q.sync[PIN_DATA_LSB +: DATA_W];

  assign pclk_rise = pclk_s & ~q.pclk_prev;
  assign rd_fall   = q.rd_prev_n & ~rd_n_s;
  assign rd_rise   = ~q.rd_prev_n & rd_n_s;
  assign wr_fall   = q.wr_prev_n & ~wr_n_s;
  assign wr_rise   = ~q.wr_prev_n & wr_n_s;

  // Index and blank are taken from the same synchronised word as the clock
  // edge; the pixel source must hold them stable around its clock edge.
  assign sample_in = {q.sync[PIN_BLANK_N], q.sync[PIN_INDEX_LSB +: PIXEL_W]};

  // A table transfer takes the place of one pixel look-up
  assign fifo_pop = fifo_out_valid & ~tbl_busy;

  // Samples arriving while full are lost; o_pixel_ready warns the source
  sample_fifo #(
    .WIDTH (SAMPLE_W),
    .DEPTH (FIFO_DEPTH)
  ) u_sample_fifo (
    .i_mclk      (i_mclk),
    .i_reset     (i_reset),
    .i_in_valid  (pclk_rise),
    .o_in_ready  (o_pixel_ready),
    .i_in_data   (sample_in),
    .o_out_valid (fifo_out_valid),
    .i_out_ready (~tbl_busy),
    .o_out_data  (fifo_out_data)
  );

  // Read byte of the colour buffer for the current phase; top bits read zero
  function automatic logic [DATA_W-1:0] colour_byte(
    input logic [ENTRY_W-1:0] entry,
    input phase_e             phase
  );
    logic [COLOUR_W-1:0] code;
    unique case (phase)
      PH_RED:   code = entry[RED_LSB +: COLOUR_W];
      PH_GREEN: code = entry[GREEN_LSB +: COLOUR_W];
      PH_BLUE:  code = entry[BLUE_LSB +: COLOUR_W];
      default:  code = '0;
    endcase
    return {{(DATA_W - COLOUR_W){1'b0}}, code};
  endfunction

  // Zero code while blanked, whatever the entry holds
  function automatic logic [COLOUR_W-1:0] gate(
    input logic [COLOUR_W-1:0] code,
    input logic                blank_n
  );
    return blank_n ? code : '0;
  endfunction

  // Every field named so that a new field cannot be left out of reset;
  // strobes and pixel clock start at their idle levels to avoid a false edge
  function automatic state_s reset_state();
    state_s r;
    r.meta       = PIN_RESET;
    r.sync       = PIN_RESET;
    r.pclk_prev  = 1'b0;
    r.rd_prev_n  = 1'b1;
    r.wr_prev_n  = 1'b1;
    r.sel        = SEL_ADDR_WRITE;
    r.addr       = ADDR_RESET;
    r.mask       = MASK_RESET;
    r.cbuf       = '0;
    r.phase      = PH_RED;
    r.rd_data    = '0;
    r.oe         = 1'b0;
    r.ack        = 1'b0;
    r.s1_valid   = 1'b0;
    r.s1_blank_n = 1'b0;
    r.s1_addr    = '0;
    r.s2_valid   = 1'b0;
    r.s2_blank_n = 1'b0;
    r.s2_entry   = '0;
    r.red        = '0;
    r.green      = '0;
    r.blue       = '0;
    return r;
  endfunction

  always_comb begin
    d = q;
    tbl_busy = 1'b0;
    pal_we = 1'b0;
    pal_wa = q.addr;
    pal_wd = q.cbuf;
    d.ack = 1'b0;

    d.meta = pins;
    // Three-cycle pin latency is the spacing the host must leave
    d.sync = q.meta;
    d.pclk_prev = pclk_s;
    d.rd_prev_n = rd_n_s;
    d.wr_prev_n = wr_n_s;

    if (rd_fall || wr_fall) begin
      d.sel = sel_s;
    end

    // Read start: data latched once so it stands for the whole strobe
    if (rd_fall) begin
      d.oe = 1'b1;
      unique case (sel_s)
        SEL_COLOUR: d.rd_data = colour_byte(q.cbuf, q.phase);
        SEL_MASK: d.rd_data = q.mask;
        SEL_ADDR_WRITE,
        SEL_ADDR_READ: d.rd_data = q.addr;
      endcase
    end

    // Read end: release the bus and step the colour phase in the same cycle
    if (rd_rise) begin
      d.oe = 1'b0;
      d.ack = 1'b1;
      if (q.sel == SEL_COLOUR) begin
        unique case (q.phase)
          PH_RED:   d.phase = PH_GREEN;
          PH_GREEN: d.phase = PH_BLUE;
          PH_BLUE: begin
            d.phase = PH_RED;
            d.cbuf = palette[q.addr];
            d.addr = q.addr + 1'b1;
            tbl_busy = 1'b1;
          end
          default: d.phase = PH_RED;
        endcase
      end
    end

    // Write end: data comes from the same synchronised word as the strobe
    if (wr_rise) begin
      d.ack = 1'b1;
      unique case (q.sel)
        SEL_ADDR_WRITE: begin
          d.addr = data_s;
          d.phase = PH_RED;
        end
        SEL_ADDR_READ: begin
          d.phase = PH_RED;
          d.cbuf = palette[data_s];
          d.addr = data_s + 1'b1;
          tbl_busy = 1'b1;
        end
        SEL_MASK: d.mask = data_s;
        SEL_COLOUR: begin
          unique case (q.phase)
            PH_RED: begin
              d.cbuf[RED_LSB +: COLOUR_W] = data_s[COLOUR_W-1:0];
              d.phase = PH_GREEN;
            end
            PH_GREEN: begin
              d.cbuf[GREEN_LSB +: COLOUR_W] = data_s[COLOUR_W-1:0];
              d.phase = PH_BLUE;
            end
            PH_BLUE: begin
              d.cbuf[BLUE_LSB +: COLOUR_W] = data_s[COLOUR_W-1:0];
              pal_we = 1'b1;
              pal_wd = {q.cbuf[ENTRY_W-1:COLOUR_W], data_s[COLOUR_W-1:0]};
              d.addr = q.addr + 1'b1;
              d.phase = PH_RED;
              tbl_busy = 1'b1;
            end
            default: d.phase = PH_RED;
          endcase
        end
      endcase
    end

    // Stage 1: masked table address
    d.s1_valid = fifo_pop;
    if (fifo_pop) begin
      d.s1_blank_n = fifo_out_data[PIXEL_W];
      d.s1_addr = fifo_out_data[PIXEL_W-1:0] & q.mask;
    end

    // Stage 2: table read; a table write in this cycle shows one pixel later
    d.s2_valid = q.s1_valid;
    if (q.s1_valid) begin
      d.s2_blank_n = q.s1_blank_n;
      d.s2_entry = palette[q.s1_addr];
    end

    // Stage 3: colour codes, zero while blanked
    if (q.s2_valid) begin
      d.red   = gate(q.s2_entry[RED_LSB +: COLOUR_W], q.s2_blank_n);
      d.green = gate(q.s2_entry[GREEN_LSB +: COLOUR_W], q.s2_blank_n);
      d.blue  = gate(q.s2_entry[BLUE_LSB +: COLOUR_W], q.s2_blank_n);
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      q <= reset_state();
    end else begin
      q <= d;
    end
  end

  // Table contents are not reset; software loads them before display
  always_ff @(posedge i_mclk) begin
    if (pal_we) begin
      palette[pal_wa] <= pal_wd;
    end
  end

  // All outputs except o_pixel_ready come straight from registers; o_pixel_ready is decoded from the FIFO count
  assign o_program_data_bus    = q.rd_data;
  assign o_program_data_bus_oe = q.oe;
  assign o_red                 = q.red;
  assign o_green               = q.green;
  assign o_blue                = q.blue;
  assign o_host_ack            = q.ack;

endmodule

// ===== core/palette_pkg.sv
// Package for the colour palette look-up block: widths, field layout,
// register select codes and reset values.
// Assumes a single core clock; every pin is synchronised before use.
package palette_pkg;

  localparam int PIXEL_W   = 8;
  localparam int COLOUR_W  = 6;
  localparam int ENTRY_W   = 3 * COLOUR_W;
  localparam int ENTRIES   = 256;
  localparam int DATA_W    = 8;
  localparam int SEL_W     = 2;
  localparam int FIFO_DEPTH = 16;
  localparam int SAMPLE_W  = PIXEL_W + 1;

  // Palette entry layout: red high, blue low
  localparam int RED_LSB   = 12;
  localparam int GREEN_LSB = 6;
  localparam int BLUE_LSB  = 0;

  // Register select codes
  localparam logic [SEL_W-1:0] SEL_ADDR_WRITE = 2'h0;
  localparam logic [SEL_W-1:0] SEL_COLOUR     = 2'h1;
  localparam logic [SEL_W-1:0] SEL_MASK       = 2'h2;
  localparam logic [SEL_W-1:0] SEL_ADDR_READ  = 2'h3;

  // Pin synchroniser vector layout
  localparam int PIN_DATA_LSB  = 0;
  localparam int PIN_SEL_LSB   = 8;
  localparam int PIN_WR_N      = 10;
  localparam int PIN_RD_N      = 11;
  localparam int PIN_INDEX_LSB = 12;
  localparam int PIN_BLANK_N   = 20;
  localparam int PIN_PCLK      = 21;
  localparam int PIN_W         = 22;

  // Strobes idle high after reset so no false edge is seen
  localparam logic [PIN_W-1:0]   PIN_RESET  = 22'h000C00;
  localparam logic [PIXEL_W-1:0] MASK_RESET = 8'hFF;
  localparam logic [PIXEL_W-1:0] ADDR_RESET = 8'h00;

  typedef enum logic [1:0] {
    PH_RED   = 2'h0,
    PH_GREEN = 2'h1,
    PH_BLUE  = 2'h3
  } phase_e;

endpackage

// ===== core/sample_fifo.sv
// Synchronous FIFO with valid/ready on both sides.
// Assumes both sides run on the same clock; storage is plain flops.
module sample_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input  wire logic             i_mclk,
  input  wire logic             i_reset,
  input  wire logic             i_in_valid,
  output logic                  o_in_ready,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_out_valid,
  input  wire logic             i_out_ready,
  output logic      [WIDTH-1:0] o_out_data
);
  localparam int PTR_W = $clog2(DEPTH);
  localparam int CNT_W = $clog2(DEPTH + 1);
  localparam logic [CNT_W-1:0] FULL_COUNT = CNT_W'(DEPTH);
  localparam logic [PTR_W-1:0] LAST_PTR   = PTR_W'(DEPTH - 1);

  typedef struct packed {
    logic [PTR_W-1:0] wr_ptr;
    logic [PTR_W-1:0] rd_ptr;
    logic [CNT_W-1:0] count;
  } fifo_s;

  fifo_s            q;
  fifo_s            d;
  logic [WIDTH-1:0] mem [DEPTH];
  logic             push;
  logic             pop;

  assign o_in_ready  = (q.count != FULL_COUNT);
  assign o_out_valid = (q.count != '0);
  assign o_out_data  = mem[q.rd_ptr];
  assign push        = i_in_valid & o_in_ready;
  assign pop         = o_out_valid & i_out_ready;

  always_comb begin
    d = q;
    if (push) begin
      d.wr_ptr = (q.wr_ptr == LAST_PTR) ? '0 : q.wr_ptr + 1'b1;
    end
    if (pop) begin
      d.rd_ptr = (q.rd_ptr == LAST_PTR) ? '0 : q.rd_ptr + 1'b1;
    end
    if (push && !pop) begin
      d.count = q.count + 1'b1;
    end else if (pop && !push) begin
      d.count = q.count - 1'b1;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (i_reset) begin
      q <= '0;
    end else begin
      q <= d;
    end
  end

  always_ff @(posedge i_mclk) begin
    if (push) begin
      mem[q.wr_ptr] <= i_in_data;
    end
  end

endmodule

// ===== testbench/colour_palette_lookup_tb.sv
// Self-checking bench for the palette block with the host and pixel model.
// Assumes the model changes pins 1 ns after a clock edge.
module colour_palette_lookup_tb;
  import palette_pkg::*;
  timeunit 1ns;
  timeprecision 1ns;
  logic       mclk = 1'b0;
  logic       reset = 1'b1;
  logic       pclk, blank_n, rd_n, wr_n, oe, ready, ack;
  logic [7:0] index, host_bus, dout, bus;
  logic [1:0] sel;
  logic [5:0] red, green, blue;
  int         n_fail = 0;
  int         n_compared = 0;
  logic [7:0] wdat [6] = '{8'h2A, 8'h15, 8'h3F, 8'hC1, 8'h22, 8'h4C};
  always #20 mclk = ~mclk;
  assign bus = oe ? dout : host_bus;
  colour_palette_lookup u_colour_palette_lookup (
    .i_mclk(mclk), .i_reset(reset), .i_pixel_clock(pclk), .i_pixel_index_in(index),
    .i_blank_n(blank_n), .i_rd_n(rd_n), .i_wr_n(wr_n), .i_register_select(sel),
    .i_program_data_bus(bus), .o_program_data_bus(dout), .o_program_data_bus_oe(oe),
    .o_red(red), .o_green(green), .o_blue(blue), .o_pixel_ready(ready), .o_host_ack(ack)
  );
  host_pixel_model u_host_pixel_model (
    .i_mclk(mclk), .i_bus(bus), .o_pclk(pclk), .o_index(index), .o_blank_n(blank_n),
    .o_rd_n(rd_n), .o_wr_n(wr_n), .o_sel(sel), .o_bus(host_bus)
  );
  task automatic finish_test();
    if (n_fail == 0 && n_compared > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_rgb(input logic [17:0] exp);
    n_compared++;
    if ({red, green, blue} !== exp) begin
      n_fail++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, {red, green, blue}, exp);
    end
  endtask
  task automatic wr(input logic [1:0] s, input logic [7:0] d);
    u_host_pixel_model.bus_write(s, d);
  endtask
  task automatic rd(input logic [1:0] s, output logic [7:0] d);
    u_host_pixel_model.bus_read(s, d);
  endtask
  task automatic t_table();
    logic [7:0] d;
    wr(SEL_ADDR_WRITE, 8'h10);
    foreach (wdat[i]) wr(SEL_COLOUR, wdat[i]);
    wr(SEL_ADDR_READ, 8'h10);
    foreach (wdat[i]) begin
      rd(SEL_COLOUR, d);
      chk8(d, wdat[i] & 8'h3F);
    end
    rd(SEL_ADDR_WRITE, d);
    chk8(d, 8'h13);
    rd(SEL_ADDR_READ, d);
    chk8(d, 8'h13);
  endtask
  task automatic t_restart();
    logic [7:0] d;
    wr(SEL_ADDR_WRITE, 8'h20);
    wr(SEL_COLOUR, 8'h3F);
    wr(SEL_ADDR_WRITE, 8'h20);
    for (int i = 1; i < 4; i++) wr(SEL_COLOUR, 8'(i));
    wr(SEL_ADDR_READ, 8'h20);
    for (int i = 1; i < 4; i++) begin
      rd(SEL_COLOUR, d);
      chk8(d, 8'(i));
    end
  endtask
  task automatic t_pixel();
    u_host_pixel_model.pixel(8'h11, 1'b1);
    chk8({7'h00, ready}, 8'h01);
    chk_rgb({6'h01, 6'h22, 6'h0C});
    u_host_pixel_model.pixel(8'h10, 1'b1);
    chk_rgb({6'h2A, 6'h15, 6'h3F});
  endtask
  task automatic t_mask();
    logic [7:0] d;
    rd(SEL_MASK, d);
    chk8(d, MASK_RESET);
    wr(SEL_MASK, 8'hFE);
    rd(SEL_MASK, d);
    chk8(d, 8'hFE);
    u_host_pixel_model.pixel(8'h11, 1'b1);
    chk_rgb({6'h2A, 6'h15, 6'h3F});
    wr(SEL_MASK, 8'hFF);
  endtask
  task automatic t_blank();
    repeat (3) u_host_pixel_model.pixel(8'h11, 1'b0);
    chk_rgb(18'h00000);
    u_host_pixel_model.pixel(8'h20, 1'b1);
    chk_rgb({6'h01, 6'h02, 6'h03});
  endtask
  initial begin
    #200000;
    n_fail++;
    finish_test();
  end
  initial begin
    repeat (16) @(posedge mclk);
    #1;
    reset = 1'b0;
    t_table();
    t_restart();
    t_pixel();
    t_mask();
    t_blank();
    finish_test();
  end
endmodule

// ===== testbench/host_pixel_model.sv
// Host processor and pixel source driving the palette block pins.
// Assumes the bench resolves the data bus from the block's enable.
module host_pixel_model (
  input  wire logic       i_mclk,
  input  wire logic [7:0] i_bus,
  output logic            o_pclk,
  output logic      [7:0] o_index,
  output logic            o_blank_n,
  output logic            o_rd_n,
  output logic            o_wr_n,
  output logic      [1:0] o_sel,
  output logic      [7:0] o_bus
);
  timeunit 1ns;
  timeprecision 1ns;
  initial begin
    o_pclk = 1'b0;
    o_index = 8'h00;
    o_blank_n = 1'b1;
    o_rd_n = 1'b1;
    o_wr_n = 1'b1;
    o_sel = 2'h0;
    o_bus = 8'h00;
  end
  task automatic step(input int n);
    repeat (n) @(posedge i_mclk);
    #1;
  endtask
  task automatic bus_write(input logic [1:0] sel, input logic [7:0] d);
    o_sel = sel;
    o_bus = d;
    o_wr_n = 1'b0;
    step(5);
    o_wr_n = 1'b1;
    step(2);
    o_bus = ~d;  // Released bus must not keep the last byte
    step(5);
  endtask
  task automatic bus_read(input logic [1:0] sel, output logic [7:0] d);
    o_sel = sel;
    o_rd_n = 1'b0;
    repeat (6) @(posedge i_mclk);
    d = i_bus;
    #1;
    o_rd_n = 1'b1;
    step(7);
  endtask
  task automatic pixel(input logic [7:0] idx, input logic blank_n);
    o_index = idx;
    o_blank_n = blank_n;
    step(4);
    o_pclk = 1'b1;
    step(4);
    o_pclk = 1'b0;
    step(4);
  endtask
endmodule

// ===== testbench/palette_chk.sv
// Port checker for the palette block: host bus, acknowledge, blanking.
// Assumes strobes and pixel clock change slowly against i_mclk.
module palette_chk (
  input wire logic       i_mclk,
  input wire logic       i_reset,
  input wire logic       i_pixel_clock,
  input wire logic       i_blank_n,
  input wire logic       i_rd_n,
  input wire logic       i_wr_n,
  input wire logic [7:0] o_program_data_bus,
  input wire logic       o_program_data_bus_oe,
  input wire logic [5:0] o_red,
  input wire logic [5:0] o_green,
  input wire logic [5:0] o_blue,
  input wire logic       o_host_ack
);
  timeunit 1ns;
  timeprecision 1ns;
  // Pixel edges seen while blank stays low; three flush the pipeline
  logic [1:0] edges_q;
  logic       pclk_q;
  always_ff @(posedge i_mclk) begin
    pclk_q <= i_pixel_clock;
    if (i_reset || i_blank_n)
      edges_q <= 2'h0;
    else if (i_pixel_clock && !pclk_q && edges_q != 2'h3)
      edges_q <= edges_q + 2'h1;
  end
  default clocking @(posedge i_mclk); endclocking
  default disable iff (i_reset);
  AST_OE_ON: assert property (!i_rd_n [*6] |-> o_program_data_bus_oe)
    else $error("bus not driven in read");
  AST_OE_OFF: assert property (i_rd_n [*6] |-> !o_program_data_bus_oe)
    else $error("bus driven after read");
  AST_OE_WRITE: assert property (!i_wr_n [*6] |-> !o_program_data_bus_oe)
    else $error("bus driven in write");
  AST_DATA_HOLD: assert property (o_program_data_bus_oe [*3] |-> $stable(o_program_data_bus))
    else $error("read data moved");
  AST_ACK_AFTER: assert property ($rose(i_wr_n) || $rose(i_rd_n) |-> ##[2:5] o_host_ack)
    else $error("no acknowledge");
  AST_ACK_PULSE: assert property (o_host_ack |=> !o_host_ack)
    else $error("acknowledge too long");
  AST_ACK_CAUSE: assert property ($rose(o_host_ack) |-> $past(i_rd_n, 2) && $past(i_wr_n, 2))
    else $error("acknowledge without strobe rise");
  AST_BLANK: assert property (edges_q == 2'h3 |-> {o_red, o_green, o_blue} == 18'h00000)
    else $error("colour during blank");
  cover property (o_host_ack);
  cover property ($rose(o_program_data_bus_oe));
  cover property (edges_q == 2'h3);
endmodule

bind colour_palette_lookup palette_chk u_palette_chk (
  .i_mclk, .i_reset, .i_pixel_clock, .i_blank_n, .i_rd_n, .i_wr_n, .o_program_data_bus,
  .o_program_data_bus_oe, .o_red, .o_green, .o_blue, .o_host_ack
);
